// ==== src/aqs_consts.vh ====
// constants and function list for the adc queue sequencer
// Function
// - approximation resolves from msb down to lsb, one bit per step
// - after ten bits the value goes into the command's result entry
// - a table of 64 command words, each selecting one channel
// - one or two queues convert their commands in order and store results
// - queue 1 takes precedence over queue 2 when both contend
// - with both queues idle, a trigger starts its queue at once
// - queue 2 trigger during queue 1 becomes pending until queue 1 stops
// - further queue 2 triggers while pending flag a trigger overrun, except in software modes
// - queue 1 trigger during queue 2 aborts queue 2 and suspends it
// - queue 2 triggers while suspended flag a trigger overrun, except in software modes
// - suspended queue 2 resumes when queue 1 stops; resume bit picks word
// - simultaneous triggers start queue 1 and leave queue 2 pending
// - a pause bit marks the final entry of a sub-queue
// - each queue's mode selects the trigger type that starts its sub-queues
// - single or continuous scan applies to the whole queue
// - after a pause continue with next word; no sub-queue rerun early
// - trigger during an executing sub-queue is ignored; sets overrun except in software modes
// - continuous scan trigger after completion restarts at first word
// - pause word finishes its conversion, then pauses and sets pause flag
// - outside software modes, paused status is shown and a new trigger starts the next sub-queue
// - channel 63 ends the queue: completion set, idle, no conversion
// - two initial unless bypassed, then 2/4/8/16 final, then ten resolution cycles
`ifndef AQS_CONSTS_VH
`define AQS_CONSTS_VH

// ==========================================================
// register offsets
`define AQS_REG_Q1CTRL    8'h00
`define AQS_REG_Q2CTRL    8'h01
`define AQS_REG_STATUS    8'h02
`define AQS_REG_FLAGS     8'h03
`define AQS_REG_CCW_BASE  8'h40
`define AQS_REG_RES_BASE  8'h80

// ==========================================================
// command word fields
`define AQS_CCW_CHAN_LSB  0
`define AQS_CCW_CHAN_MSB  5
`define AQS_CCW_IST_LSB   6
`define AQS_CCW_IST_MSB   7
`define AQS_CCW_BYP       8
`define AQS_CCW_PAUSE     9
`define AQS_EOQ_CHAN      6'h3F

// ==========================================================
// queue control fields: mode[2:0], single-scan enable 3, resume 4, start index 11:5
`define AQS_QC_MODE_MSB   2
`define AQS_QC_SSE        3
`define AQS_QC_RESUME     4
`define AQS_QC_BQ2_LSB    5
`define AQS_QC_BQ2_MSB    11

// queue modes
`define AQS_MODE_OFF      3'h0
`define AQS_MODE_SW_SS    3'h1
`define AQS_MODE_EXT_SS   3'h2
`define AQS_MODE_TMR_SS   3'h3
`define AQS_MODE_SW_CS    3'h5
`define AQS_MODE_EXT_CS   3'h6
`define AQS_MODE_TMR_CS   3'h7

// queue status codes
`define AQS_ST_IDLE       3'h0
`define AQS_ST_ACTIVE     3'h1
`define AQS_ST_PAUSED     3'h2
`define AQS_ST_PENDING    3'h3
`define AQS_ST_SUSPEND    3'h4

// ==========================================================
// timing in converter clock cycles
`define AQS_T_INITIAL     5'h02
`define AQS_T_RESOLVE     4'hA
`define AQS_RES_BITS      10

`endif

// ==== src/aqs_sar.v ====
// successive approximation engine with sample phase timing
`timescale 1ns/1ps
`include "aqs_consts.vh"

module aqs_sar #(
    parameter BITS = `AQS_RES_BITS
) (
    // clock and reset
    input  wire            clk,
    input  wire            reset,
    // control
    input  wire            start,
    input  wire            abort,
    input  wire [1:0]      sampleSel,
    input  wire            bypass,
    // analog front end
    input  wire            compHigh,
    output reg             sampleAmp,
    output reg             sampleDirect,
    output reg  [BITS-1:0] dacCode,
    // result
    output reg             busy,
    output reg             done,
    output reg  [BITS-1:0] result
);
    // ==========================================================
    // phase machine
    localparam PH_IDLE = 2'h0;
    localparam PH_INIT = 2'h1;
    localparam PH_FINAL = 2'h2;
    localparam PH_RES  = 2'h3;

    reg [1:0]      phase;
    reg [4:0]      count;
    reg [BITS-1:0] trial;
    reg [BITS-1:0] acc;
    wire [4:0]     finalLen = 5'h02 << sampleSel;

    always @(posedge clk) begin
        done <= 1'b0;
        if (reset || abort) begin
            phase        <= PH_IDLE;
            count        <= 5'h00;
            trial        <= {BITS{1'b0}};
            acc          <= {BITS{1'b0}};
            busy         <= 1'b0;
            sampleAmp    <= 1'b0;
            sampleDirect <= 1'b0;
            dacCode      <= {BITS{1'b0}};
            if (reset) begin
                result <= {BITS{1'b0}};
            end
        end else begin
            case (phase)
                PH_IDLE: begin
                    if (start) begin
                        busy <= 1'b1;
                        // bypass skips the buffered phase; final sample takes its place
                        if (bypass) begin
                            phase        <= PH_FINAL;
                            count        <= finalLen;
                            sampleDirect <= 1'b1;
                        end else begin
                            phase     <= PH_INIT;
                            count     <= `AQS_T_INITIAL;
                            sampleAmp <= 1'b1;
                        end
                    end
                end
                PH_INIT: begin
                    if (count == 5'h01) begin
                        phase        <= PH_FINAL;
                        count        <= finalLen;
                        sampleAmp    <= 1'b0;
                        sampleDirect <= 1'b1;
                    end else begin
                        count <= count - 5'h01;
                    end
                end
                PH_FINAL: begin
                    if (count == 5'h01) begin
                        phase        <= PH_RES;
                        sampleDirect <= 1'b0;
                        trial        <= {1'b1, {(BITS-1){1'b0}}};
                        acc          <= {BITS{1'b0}};
                        dacCode      <= {1'b1, {(BITS-1){1'b0}}};
                    end else begin
                        count <= count - 5'h01;
                    end
                end
                PH_RES: begin
                    // one decision per cycle, ten cycles total
                    if (compHigh) begin
                        acc <= acc | trial;
                    end
                    trial   <= trial >> 1;
                    dacCode <= (compHigh ? (acc | trial) : acc) | (trial >> 1);
                    if (trial[0]) begin
                        phase  <= PH_IDLE;
                        busy   <= 1'b0;
                        done   <= 1'b1;
                        result <= compHigh ? (acc | trial) : acc;
                    end
                end
                default: phase <= PH_IDLE;
            endcase
        end
    end
endmodule

// ==== src/aqs_trig_sel.v ====
// selects the trigger that a queue mode responds to
`timescale 1ns/1ps
`include "aqs_consts.vh"

module aqs_trig_sel (
    // mode and sources
    input  wire [2:0] mode,
    input  wire       swTrig,
    input  wire       extTrig,
    input  wire       tmrTrig,
    // outputs
    output reg        trig,
    output reg        continuous,
    output reg        softMode
);
    always @* begin
        trig       = 1'b0;
        continuous = mode[2];
        softMode   = 1'b0;
        case (mode)
            `AQS_MODE_SW_SS, `AQS_MODE_SW_CS: begin
                trig     = swTrig;
                softMode = 1'b1;
            end
            `AQS_MODE_EXT_SS, `AQS_MODE_EXT_CS: trig = extTrig;
            `AQS_MODE_TMR_SS, `AQS_MODE_TMR_CS: trig = tmrTrig;
            default: trig = 1'b0;
        endcase
    end
endmodule

// ==== src/aqs_queue_ctrl.v ====
// queue sequencer top: command table, two queues, result table, register port
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "aqs_consts.vh"

module aqs_queue_ctrl #(
    parameter DEPTH = 64,
    parameter BITS  = `AQS_RES_BITS
) (
    // clock and reset
    input  wire            clk,
    input  wire            reset,
    // register port
    input  wire [7:0]      regAddr,
    input  wire [15:0]     regWrData,
    input  wire            regWrite,
    input  wire            regRead,
    output reg  [15:0]     regRdData,
    // trigger pins
    input  wire            extTrig1,
    input  wire            extTrig2,
    input  wire            tmrTrig1,
    input  wire            tmrTrig2,
    // analog front end
    input  wire            compHigh,
    output reg  [5:0]      channelSel,
    output wire            sampleAmp,
    output wire            sampleDirect,
    output wire [BITS-1:0] dacCode,
    // event outputs
    output reg             pauseEvent1,
    output reg             pauseEvent2
);
    // ==========================================================
    // storage
    reg [9:0]      ccwTable [0:DEPTH-1];
    reg [BITS-1:0] resTable [0:DEPTH-1];

    reg [11:0] q1Ctrl;
    reg [11:0] q2Ctrl;
    reg [2:0]  q1Stat;
    reg [2:0]  q2Stat;
    reg [5:0]  q1Ptr;
    reg [5:0]  q2Ptr;
    reg [5:0]  q2Sub;
    reg        q1Sse;
    reg        q2Sse;
    reg        q1Done, q2Done;
    reg        q1Pause, q2Pause;
    reg        q1Ovr, q2Ovr;
    reg        q1SwTrig, q2SwTrig;
    reg        running;
    reg        runQ2;
    reg [5:0]  runIdx;

    // ==========================================================
    // pin synchronisers
    reg [3:0] trigMeta;
    reg [3:0] trigSync;
    reg [3:0] trigLast;
    always @(posedge clk) begin
        if (reset) begin
            trigMeta <= 4'h0;
            trigSync <= 4'h0;
            trigLast <= 4'h0;
        end else begin
            trigMeta <= {tmrTrig2, tmrTrig1, extTrig2, extTrig1};
            trigSync <= trigMeta;
            trigLast <= trigSync;
        end
    end
    wire [3:0] trigRise = trigSync & ~trigLast;

    // ==========================================================
    // trigger selection per queue
    wire t1Raw, t2Raw, cont1, cont2, soft1, soft2;
    aqs_trig_sel uSel1 (
        .mode       (q1Ctrl[`AQS_QC_MODE_MSB:0]),
        .swTrig     (q1SwTrig),
        .extTrig    (trigRise[0]),
        .tmrTrig    (trigRise[2]),
        .trig       (t1Raw),
        .continuous (cont1),
        .softMode   (soft1)
    );
    aqs_trig_sel uSel2 (
        .mode       (q2Ctrl[`AQS_QC_MODE_MSB:0]),
        .swTrig     (q2SwTrig),
        .extTrig    (trigRise[1]),
        .tmrTrig    (trigRise[3]),
        .trig       (t2Raw),
        .continuous (cont2),
        .softMode   (soft2)
    );
    // single scan needs its enable; continuous runs on every trigger
    wire trig1 = t1Raw & (cont1 | q1Sse);
    wire trig2 = t2Raw & (cont2 | q2Sse);

    // ==========================================================
    // converter
    wire       sarBusy, sarDone;
    wire [BITS-1:0] sarResult;
    reg        sarStart;
    reg        sarAbort;
    wire [9:0] runWord = ccwTable[runIdx];
    wire [5:0] q2Base  = q2Ctrl[`AQS_QC_BQ2_LSB+5:`AQS_QC_BQ2_LSB];
    wire       q2Beyond = q2Ctrl[`AQS_QC_BQ2_MSB];

    aqs_sar #(.BITS(BITS)) uSar (
        .clk          (clk),
        .reset        (reset),
        .start        (sarStart),
        .abort        (sarAbort),
        .sampleSel    (runWord[`AQS_CCW_IST_MSB:`AQS_CCW_IST_LSB]),
        .bypass       (runWord[`AQS_CCW_BYP]),
        .compHigh     (compHigh),
        .sampleAmp    (sampleAmp),
        .sampleDirect (sampleDirect),
        .dacCode      (dacCode),
        .busy         (sarBusy),
        .done         (sarDone),
        .result       (sarResult)
    );
    always @(posedge clk) begin
        if (reset) begin
            channelSel <= 6'h00;
        end else begin
            channelSel <= runWord[`AQS_CCW_CHAN_MSB:`AQS_CCW_CHAN_LSB];
        end
    end

    // end of queue test, shared by both queues
    function isEnd;
        input [5:0] idx;
        input       forQ1;
        begin
            isEnd = (ccwTable[idx][5:0] == `AQS_EOQ_CHAN) ||
                    (forQ1 && !q2Beyond && idx == q2Base);
        end
    endfunction

    // ==========================================================
    // queue sequencing
    wire q1Exec = running && !runQ2;
    wire q2Exec = running && runQ2;
    wire q1Ready = (q1Stat == `AQS_ST_PENDING);
    wire q2Ready = (q2Stat == `AQS_ST_PENDING) || (q2Stat == `AQS_ST_SUSPEND);
    wire lastBit = (runIdx == 6'h3F);

    always @(posedge clk) begin
        sarStart    <= 1'b0;
        sarAbort    <= 1'b0;
        pauseEvent1 <= 1'b0;
        pauseEvent2 <= 1'b0;
        if (reset) begin
            q1Stat  <= `AQS_ST_IDLE;
            q2Stat  <= `AQS_ST_IDLE;
            q1Ptr   <= 6'h00;
            q2Ptr   <= 6'h00;
            q2Sub   <= 6'h00;
            q1Done  <= 1'b0;
            q2Done  <= 1'b0;
            q1Pause <= 1'b0;
            q2Pause <= 1'b0;
            q1Ovr   <= 1'b0;
            q2Ovr   <= 1'b0;
            q1Sse   <= 1'b0;
            q2Sse   <= 1'b0;
            running <= 1'b0;
            runQ2   <= 1'b0;
            runIdx  <= 6'h00;
        end else begin
            // software clear of flags; hardware sets below win
            if (regWrite && regAddr == `AQS_REG_FLAGS) begin
                q1Done  <= q1Done  & ~regWrData[0];
                q2Done  <= q2Done  & ~regWrData[1];
                q1Pause <= q1Pause & ~regWrData[2];
                q2Pause <= q2Pause & ~regWrData[3];
                q1Ovr   <= q1Ovr   & ~regWrData[4];
                q2Ovr   <= q2Ovr   & ~regWrData[5];
            end
            if (regWrite && regAddr == `AQS_REG_Q1CTRL && regWrData[`AQS_QC_SSE]) begin
                q1Sse <= 1'b1;
            end
            if (regWrite && regAddr == `AQS_REG_Q2CTRL && regWrData[`AQS_QC_SSE]) begin
                q2Sse <= 1'b1;
            end

            // queue 1 trigger handling
            if (trig1) begin
                if (q1Exec || q1Ready) begin
                    if (!soft1) q1Ovr <= 1'b1;
                end else begin
                    if (q1Stat == `AQS_ST_IDLE) q1Ptr <= 6'h00;
                    q1Stat <= `AQS_ST_PENDING;
                    if (q2Exec) begin
                        sarAbort <= 1'b1;
                        running  <= 1'b0;
                        q2Stat   <= `AQS_ST_SUSPEND;
                        q2Ptr    <= runIdx;
                    end
                end
            end

            // queue 2 trigger handling
            if (trig2) begin
                if (q2Exec || q2Ready) begin
                    if (!soft2) q2Ovr <= 1'b1;
                end else if (!(trig1 && q2Exec)) begin
                    if (q2Stat == `AQS_ST_IDLE) begin
                        q2Ptr <= q2Base;
                        q2Sub <= q2Base;
                    end
                    q2Stat <= `AQS_ST_PENDING;
                end
            end

            // dispatch: queue 1 first
            if (!running && !sarBusy && !sarAbort) begin
                if (q1Ready && !trig1) begin
                    running <= 1'b1;
                    runQ2   <= 1'b0;
                    runIdx  <= q1Ptr;
                    q1Stat  <= `AQS_ST_ACTIVE;
                end else if (q2Ready && !trig1 && !trig2 && !q1Exec) begin
                    running <= 1'b1;
                    runQ2   <= 1'b1;
                    // resume bit picks the start of the sub-queue or the aborted word
                    runIdx  <= q2Ctrl[`AQS_QC_RESUME] ? q2Ptr : q2Sub;
                    q2Stat  <= `AQS_ST_ACTIVE;
                    if (q2Beyond && q2Stat == `AQS_ST_PENDING) begin
                        running <= 1'b0;
                        q2Stat  <= `AQS_ST_IDLE;
                        q2Done  <= 1'b1;
                        q2Sse   <= 1'b0;
                    end
                end
            end else if (running && !sarBusy && !sarStart && !sarDone) begin
                // word fetched: end test or start conversion
                if (isEnd(runIdx, !runQ2)) begin
                    running <= 1'b0;
                    if (runQ2) begin
                        q2Stat <= `AQS_ST_IDLE;
                        q2Done <= 1'b1;
                        q2Sse  <= 1'b0;
                    end else begin
                        q1Stat <= `AQS_ST_IDLE;
                        q1Done <= 1'b1;
                        q1Sse  <= 1'b0;
                    end
                end else begin
                    sarStart <= 1'b1;
                end
            end else if (running && sarDone) begin
                resTable[runIdx] <= sarResult;
                runIdx <= runIdx + 6'h01;
                if (lastBit || runWord[`AQS_CCW_PAUSE] ||
                    isEnd(runIdx + 6'h01, !runQ2)) begin
                    running <= 1'b0;
                end
                if (runWord[`AQS_CCW_PAUSE]) begin
                    if (runQ2) begin
                        q2Pause     <= 1'b1;
                        pauseEvent2 <= 1'b1;
                    end else begin
                        q1Pause     <= 1'b1;
                        pauseEvent1 <= 1'b1;
                    end
                end
                if (lastBit || isEnd(runIdx + 6'h01, !runQ2)) begin
                    if (runQ2) begin
                        q2Stat <= `AQS_ST_IDLE;
                        q2Done <= 1'b1;
                        q2Sse  <= 1'b0;
                    end else begin
                        q1Stat <= `AQS_ST_IDLE;
                        q1Done <= 1'b1;
                        q1Sse  <= 1'b0;
                    end
                end else if (runWord[`AQS_CCW_PAUSE]) begin
                    // software modes re-trigger themselves past a pause
                    if (runQ2) begin
                        q2Stat <= soft2 ? `AQS_ST_PENDING : `AQS_ST_PAUSED;
                        q2Ptr  <= runIdx + 6'h01;
                        q2Sub  <= runIdx + 6'h01;
                    end else begin
                        q1Stat <= soft1 ? `AQS_ST_PENDING : `AQS_ST_PAUSED;
                        q1Ptr  <= runIdx + 6'h01;
                    end
                end
            end
        end
    end

    // ==========================================================
    // software trigger pulses and control registers
    always @(posedge clk) begin
        if (reset) begin
            q1Ctrl   <= 12'h000;
            q2Ctrl   <= 12'h7F0;
            q1SwTrig <= 1'b0;
            q2SwTrig <= 1'b0;
        end else begin
            q1SwTrig <= regWrite && regAddr == `AQS_REG_Q1CTRL && regWrData[`AQS_QC_SSE];
            q2SwTrig <= regWrite && regAddr == `AQS_REG_Q2CTRL && regWrData[`AQS_QC_SSE];
            if (regWrite && regAddr == `AQS_REG_Q1CTRL) q1Ctrl <= regWrData[11:0];
            if (regWrite && regAddr == `AQS_REG_Q2CTRL) q2Ctrl <= regWrData[11:0];
        end
    end

    // command table writes use a separate process; memory needs no reset
    always @(posedge clk) begin
        if (regWrite && regAddr[7:6] == 2'h1) begin
            ccwTable[regAddr[5:0]] <= regWrData[9:0];
        end
    end

    // ==========================================================
    // read port
    always @(posedge clk) begin
        if (reset) begin
            regRdData <= 16'h0000;
        end else if (regRead) begin
            case (regAddr[7:6])
                2'h0: begin
                    case (regAddr)
                        `AQS_REG_Q1CTRL: regRdData <= {4'h0, q1Ctrl & 12'hFF7};
                        `AQS_REG_Q2CTRL: regRdData <= {4'h0, q2Ctrl & 12'hFF7};
                        `AQS_REG_STATUS: regRdData <= {10'h000, q2Stat, q1Stat};
                        `AQS_REG_FLAGS:  regRdData <= {10'h000, q2Ovr, q1Ovr,
                                                       q2Pause, q1Pause, q2Done, q1Done};
                        default:         regRdData <= 16'h0000;
                    endcase
                end
                2'h1:    regRdData <= {6'h00, ccwTable[regAddr[5:0]]};
                2'h2:    regRdData <= {{(16-BITS){1'b0}}, resTable[regAddr[5:0]]};
                default: regRdData <= 16'h0000;
            endcase
        end else begin
            regRdData <= 16'h0000;
        end
    end
endmodule

// ==== sim/aqs_afe_model.sv ====
// analog front end model: comparator against the dac trial level
`timescale 1ns/1ps
module aqs_afe_model (
    // analog side
    input  wire [9:0] level,
    input  wire [9:0] dacCode,
    // comparator
    output wire       compHigh
);
    assign compHigh = (level >= dacCode);
endmodule

// ==== sim/aqs_queue_ctrl_assertions.sv ====
// port assertions for the queue sequencer
`timescale 1ns/1ps
module aqs_qc_chk #(
    parameter BITS = 10
) (
    // clock and reset
    input wire            clk,
    input wire            reset,
    // converter side
    input wire            sampleAmp,
    input wire            sampleDirect,
    input wire [BITS-1:0] dacCode,
    input wire            pauseEvent1,
    input wire            pauseEvent2
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ==========================================
    // conversion phases and pause events
    // an abort may cut either phase short; only the normal handoffs are timed
    chk_initial_two: assert property (
        $fell(sampleAmp) && sampleDirect |-> $past(sampleAmp, 2) && !$past(sampleAmp, 3))
        else $error("bad initial length");
    chk_final_bound: assert property (
        $rose(sampleDirect) |-> ##1 (sampleDirect || !dacCode) ##[1:15] !sampleDirect)
        else $error("bad final");
    chk_phase_excl: assert property (
        !(sampleAmp && sampleDirect)) else $error("sample phases overlap");
    chk_msb_first: assert property (
        $fell(sampleDirect) && dacCode |-> ##[0:2] (dacCode == {1'b1, {(BITS-1){1'b0}}}))
        else $error("first trial code not msb");
    chk_pause1_pulse: assert property (
        pauseEvent1 |=> !pauseEvent1) else $error("pause 1 event not one cycle");
    chk_pause2_pulse: assert property (
        pauseEvent2 |=> !pauseEvent2) else $error("pause 2 event not one cycle");
    chk_pause_single: assert property (
        !(pauseEvent1 && pauseEvent2)) else $error("both queues paused at once");
    chk_pause_after: assert property (
        sampleDirect |-> !pauseEvent1 && !pauseEvent2) else $error("pause during sampling");
    cover property ($fell(sampleDirect));
    cover property (pauseEvent1);
    cover property (pauseEvent2);
endmodule

bind aqs_queue_ctrl aqs_qc_chk #(.BITS(BITS)) i_aqs_qc_chk (
    .clk(clk), .reset(reset), .sampleAmp(sampleAmp), .sampleDirect(sampleDirect),
    .dacCode(dacCode), .pauseEvent1(pauseEvent1), .pauseEvent2(pauseEvent2));

// ==== sim/test_adc_queue_sequencer.sv ====
// self-checking bench for the adc queue sequencer
`timescale 1ns/1ps
`include "aqs_consts.vh"
module test_adc_queue_sequencer;
    reg         clk = 1'b0;
    reg         reset = 1'b1;
    reg  [7:0]  regAddr = 8'h00;
    reg  [15:0] regWrData = 16'h0000;
    reg         regWrite = 1'b0;
    reg         regRead = 1'b0;
    reg         extTrig1 = 1'b0;
    reg         extTrig2 = 1'b0;
    reg  [9:0]  level = 10'h000;
    wire [15:0] regRdData;
    wire [9:0]  dacCode;
    wire [5:0]  channelSel;
    wire        compHigh, sampleAmp, sampleDirect, pauseEvent1, pauseEvent2;
    integer     failures = 0, checks_done = 0, cycles = 0;

    aqs_queue_ctrl i_aqs_queue_ctrl (.clk(clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .extTrig1(extTrig1), .extTrig2(extTrig2),
        .tmrTrig1(1'b0), .tmrTrig2(1'b0), .compHigh(compHigh), .channelSel(channelSel),
        .sampleAmp(sampleAmp), .sampleDirect(sampleDirect), .dacCode(dacCode),
        .pauseEvent1(pauseEvent1), .pauseEvent2(pauseEvent2));
    aqs_afe_model i_aqs_afe_model (.level(level), .dacCode(dacCode), .compHigh(compHigh));

    initial forever #4 clk = ~clk;
    // a hung queue never clears its status; cut the run short
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            finish_test;
        end
    end
    // ==========================================
    // bus and trigger helpers
    task wr(input [7:0] a, input [15:0] d);
        begin
            @(posedge clk);
            {regAddr, regWrData, regWrite} <= {a, d, 1'b1};
            @(posedge clk);
            regWrite <= 1'b0;
        end
    endtask
    // polls until the expected value shows, so it also serves as a wait of up to 100 reads
    task chkReg(input [7:0] a, input [15:0] exp);
        reg [15:0] v;
        integer    n;
        begin
            v = 16'hFFFF;
            for (n = 0; n < 100 && v !== exp; n = n + 1) begin
                @(posedge clk);
                {regAddr, regRead} <= {a, 1'b1};
                @(posedge clk);
                regRead <= 1'b0;
                #1 v = regRdData;
            end
            checks_done = checks_done + 1;
            if (v !== exp) begin
                failures = failures + 1;
                $display("ERROR at %0t: got %h expected %h", $time, v, exp);
            end
        end
    endtask
    // pins are synchronised inside, so hold each level two cycles
    task pulse(input [1:0] which);
        begin
            @(posedge clk);
            {extTrig2, extTrig1} <= which;
            repeat (2) @(posedge clk);
            {extTrig2, extTrig1} <= 2'b00;
        end
    endtask
    // ==========================================
    // scenarios
    task testSingle;
        begin
            level <= 10'h2A5;
            wr(`AQS_REG_CCW_BASE, 16'h0005);
            wr(8'h41, 16'h003F);
            wr(`AQS_REG_Q1CTRL, 16'h0009);
            chkReg(`AQS_REG_FLAGS, 16'h0001);
            chkReg(`AQS_REG_RES_BASE, 16'h02A5);
            chkReg(`AQS_REG_STATUS, 16'h0000);
            chkReg(8'h20, 16'h0000);
            wr(`AQS_REG_FLAGS, 16'h003F);
            wr(`AQS_REG_Q1CTRL, 16'h000D);
            chkReg(`AQS_REG_FLAGS, 16'h0001);
            wr(`AQS_REG_FLAGS, 16'h003F);
        end
    endtask
    task testPause;
        begin
            level <= 10'h155;
            wr(`AQS_REG_CCW_BASE, 16'h0201);
            wr(8'h41, 16'h0102);
            wr(8'h42, 16'h003F);
            wr(`AQS_REG_Q1CTRL, 16'h000A);
            pulse(2'b01);
            chkReg(`AQS_REG_FLAGS, 16'h0004);
            chkReg(`AQS_REG_STATUS, 16'h0002);
            chkReg(`AQS_REG_RES_BASE, 16'h0155);
            wr(`AQS_REG_FLAGS, 16'h003F);
            pulse(2'b01);
            pulse(2'b01);
            chkReg(`AQS_REG_FLAGS, 16'h0011);
            chkReg(8'h81, 16'h0155);
            wr(`AQS_REG_FLAGS, 16'h003F);
        end
    endtask
    task testPriority;
        begin
            level <= 10'h0F0;
            wr(8'h48, 16'h0209);
            wr(8'h49, 16'h003F);
            wr(`AQS_REG_Q1CTRL, 16'h000A);
            wr(`AQS_REG_Q2CTRL, 16'h010A);
            pulse(2'b11);
            chkReg(`AQS_REG_STATUS, 16'h0019);
            pulse(2'b10);
            chkReg(`AQS_REG_FLAGS, 16'h002E);
            chkReg(`AQS_REG_STATUS, 16'h0002);
            chkReg(8'h88, 16'h00F0);
            wr(`AQS_REG_FLAGS, 16'h003F);
        end
    endtask
    task testSuspend;
        integer n;
        begin
            level <= 10'h3FF;
            wr(`AQS_REG_Q2CTRL, 16'h011A);
            pulse(2'b10);
            for (n = 0; n < 100 && !sampleDirect; n = n + 1) @(posedge clk);
            checks_done = checks_done + 1;
            if (channelSel !== 6'h09) begin
                failures = failures + 1;
                $display("ERROR at %0t: got %h expected %h", $time, channelSel, 6'h09);
            end
            pulse(2'b01);
            chkReg(`AQS_REG_STATUS, 16'h0021);
            pulse(2'b10);
            chkReg(`AQS_REG_FLAGS, 16'h002B);
            chkReg(`AQS_REG_STATUS, 16'h0000);
            chkReg(8'h88, 16'h03FF);
            chkReg(8'h81, 16'h03FF);
        end
    endtask
    task finish_test;
        begin
            if (failures == 0 && checks_done > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        testSingle;
        testPause;
        testPriority;
        testSuspend;
        finish_test;
    end
endmodule
